// file: sdi_pkg.sv
// Constants for the SD host interrupt status block
package sdi_pkg;
  // Printed register indices; byte address is four times the index, low 12 bits decoded
  localparam logic [31:0] ERR_STS_CH0_IDX = 32'h4ac00032;
  localparam logic [31:0] ERR_STS_CH1_IDX = 32'h4a800032;
  localparam logic [31:0] NORM_STS_IDX    = 32'h00000030;
  localparam logic [31:0] STS_EN_IDX      = 32'h00000034;
  localparam logic [31:0] SIG_EN_IDX      = 32'h00000036;
  localparam logic [31:0] ADMA_STS_IDX    = 32'h00000054;
  localparam int          ADDR_BITS       = 12;

  // Normal status fields
  localparam int NS_CMD_DONE  = 0;
  localparam int NS_XFER_DONE = 1;
  localparam int NS_CARD_IRQ  = 8;
  localparam int NS_ERR_SUM   = 15;

  // Error status fields
  localparam int ES_CMD_TOUT  = 0;
  localparam int ES_CMD_CRC   = 1;
  localparam int ES_CMD_EBIT  = 2;
  localparam int ES_CMD_IDX   = 3;
  localparam int ES_DAT_TOUT  = 4;
  localparam int ES_DAT_CRC   = 5;
  localparam int ES_DAT_EBIT  = 6;
  localparam int ES_CUR_LIM   = 7;
  localparam int ES_AUTO_STOP = 8;
  localparam int ES_ADMA      = 9;

  // Writable / settable bit masks, reset values and the good CRC token value
  localparam logic [15:0] NORM_MASK  = 16'h0103;
  localparam logic [15:0] ERR_MASK   = 16'h037f;
  localparam logic [15:0] STS_RST    = 16'h0000;
  localparam logic [31:0] EN_RST     = 32'h00000000;
  localparam logic [2:0]  CRC_TOK_OK = 3'h2;

  // Response wait limit in card clock cycles
  localparam int CMD_TOUT_SDCLK = 64;

  typedef enum logic [1:0] {
    SDI_CMD_IDLE = 2'b01,
    SDI_CMD_WAIT = 2'b10
  } sdi_cmd_st_t;
endpackage

// file: sdi_irq_status.sv
// SD host interrupt status registers with APB access and card clock sampling
// Functional notes
// [RL1] Transfer complete wins over data timeout; timeout alone means timeout in transfer.
// [RL2] No response within 64 card clocks sets command timeout, which beats complete.
// [RL3] Error bits latch only when status-enabled; irq needs signal-enable and a set bit.
// [RL4] Write one clears an error bit, zero keeps it; many bits per write.
// [RL5] Descriptor DMA error flag, bit 9, sets on DMA transfer error.
// [RL6] DMA engine state at the error is kept in a separate status register.
// [RL7] Invalid descriptor fetched in fetch state also sets the DMA error flag.
// [RL8] Auto stop command error bit 8 sets on any 0-to-1 of its detail bits.
// [RL9] Skipped auto stop command after an earlier error also sets bit 8.
// [RL10] Current limit error bit 7 is absent and reads zero.
// [RL11] Data end bit error sets on zero end bit of read data or CRC token.
// [RL12] Data CRC error sets on read CRC mismatch or CRC token not 010.
// [RL13] Card interrupt status holds until next card irq period; write one clears.
// [RL14] Clears take effect on a card clock edge, so irq may lag the write.
// [RL15] Command index error sets when response index differs from issued command.
// [RL16] Command end bit error sets when response end bit is sampled zero.
// [RL17] Error status bits 15..10 read zero and ignore writes.
`timescale 1ns/100ps
module sdi_irq_status #(
  parameter int CHANNEL  = 0,
  parameter int ACMD_W   = 5,
  parameter int TOUT_CNT = sdi_pkg::CMD_TOUT_SDCLK
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Card clock and card side events, all sampled on card clock rising edges
  input  wire logic        sdclk_i,
  input  wire logic        cmd_start_i,
  input  wire logic [5:0]  cmd_index_i,
  input  wire logic        resp_done_i,
  input  wire logic [5:0]  resp_index_i,
  input  wire logic        resp_end_bit_i,
  input  wire logic        resp_crc_err_i,
  input  wire logic        xfer_done_i,
  input  wire logic        data_tout_i,
  input  wire logic        rd_end_i,
  input  wire logic        rd_end_bit_i,
  input  wire logic        rd_crc_err_i,
  input  wire logic        tok_valid_i,
  input  wire logic [2:0]  tok_i,
  input  wire logic        tok_end_bit_i,
  input  wire logic        adma_err_i,
  input  wire logic        descriptor_fetch_state_i,
  input  wire logic        desc_load_i,
  input  wire logic        desc_valid_i,
  input  wire logic [1:0]  adma_state_i,
  input  wire logic [ACMD_W-1:0] acmd_err_i,
  input  wire logic        acmd_skip_i,
  input  wire logic        card_irq_i,
  // Interrupt request
  output logic             irq_request_out_o
);
  // Card side sampler width: 34 single bits and fields plus the auto stop detail
  localparam int RAW_W = 34 + ACMD_W;

  // Refuse parameter values that the counters and decoders cannot serve
  if (ACMD_W < 1 || ACMD_W > 16) begin
    $error("sdi_irq_status: ACMD_W must be 1 to 16");
  end
  // The timeout counter is eight bits wide and needs at least two states
  if (TOUT_CNT < 2 || TOUT_CNT > 255) begin
    $error("sdi_irq_status: TOUT_CNT must be 2 to 255");
  end
  // Only two channel register maps exist
  if (CHANNEL < 0 || CHANNEL > 1) begin
    $error("sdi_irq_status: CHANNEL must be 0 or 1");
  end

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
    logic [31:0] byte_addr;
    byte_addr = {idx[29:0], 2'b00};
    hit = (addr[sdi_pkg::ADDR_BITS-1:0] == byte_addr[sdi_pkg::ADDR_BITS-1:0]);
  endfunction

  // Two-stage synchronisers for card clock and card side inputs
  // Data and clock pass the same depth, so event levels stand when an edge is seen
  logic [RAW_W-1:0] raw_s1_q, raw_s2_q;
  logic [2:0]       clk_sync_q;
  wire  [RAW_W-1:0] raw = {cmd_start_i, cmd_index_i, resp_done_i, resp_index_i,
                           resp_end_bit_i, resp_crc_err_i, xfer_done_i, data_tout_i,
                           rd_end_i, rd_end_bit_i, rd_crc_err_i, tok_valid_i, tok_i,
                           tok_end_bit_i, adma_err_i, descriptor_fetch_state_i,
                           desc_load_i, desc_valid_i, adma_state_i, acmd_err_i,
                           acmd_skip_i, card_irq_i};

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      raw_s1_q   <= '0;
      raw_s2_q   <= '0;
      clk_sync_q <= 3'h0;
    end else begin
      raw_s1_q   <= raw;
      raw_s2_q   <= raw_s1_q;
      clk_sync_q <= {clk_sync_q[1:0], sdclk_i};
    end
  end

  wire sd_edge = clk_sync_q[1] & ~clk_sync_q[2];

  wire              s_cmd_start, s_resp_done, s_resp_ebit, s_resp_crc, s_xfer_done;
  wire              s_data_tout, s_rd_end, s_rd_ebit, s_rd_crc, s_tok_valid, s_tok_ebit;
  wire              s_adma_err, s_fetch, s_desc_load, s_desc_valid, s_acmd_skip, s_card_irq;
  wire [5:0]        s_cmd_idx, s_resp_idx;
  wire [2:0]        s_tok;
  wire [1:0]        s_adma_state;
  wire [ACMD_W-1:0] s_acmd;
  assign {s_cmd_start, s_cmd_idx, s_resp_done, s_resp_idx, s_resp_ebit, s_resp_crc,
          s_xfer_done, s_data_tout, s_rd_end, s_rd_ebit, s_rd_crc, s_tok_valid, s_tok,
          s_tok_ebit, s_adma_err, s_fetch, s_desc_load, s_desc_valid, s_adma_state,
          s_acmd, s_acmd_skip, s_card_irq} = raw_s2_q;

  // Command response wait tracking
  sdi_pkg::sdi_cmd_st_t cmd_st_q, cmd_st_d;
  logic [7:0] tout_cnt_q, tout_cnt_d;
  logic [5:0] issued_idx_q;
  logic       cmd_tout_ev;

  always_comb begin
    cmd_st_d    = cmd_st_q;
    tout_cnt_d  = tout_cnt_q;
    cmd_tout_ev = 1'b0;
    unique case (cmd_st_q)
      sdi_pkg::SDI_CMD_IDLE: begin
        tout_cnt_d = 8'h00;
        if (s_cmd_start) begin
          cmd_st_d = sdi_pkg::SDI_CMD_WAIT;
        end
      end
      sdi_pkg::SDI_CMD_WAIT: begin
        if (tout_cnt_q == 8'(TOUT_CNT - 1)) begin
          cmd_tout_ev = 1'b1; // [RL2]
          cmd_st_d    = sdi_pkg::SDI_CMD_IDLE;
        end else if (s_resp_done) begin
          cmd_st_d = sdi_pkg::SDI_CMD_IDLE;
        end else begin
          tout_cnt_d = tout_cnt_q + 8'h01;
        end
      end
      default: begin
        cmd_st_d = sdi_pkg::SDI_CMD_IDLE;
      end
    endcase
  end

  wire resp_ok = (cmd_st_q == sdi_pkg::SDI_CMD_WAIT) & s_resp_done & ~cmd_tout_ev;

  // Event vectors seen at this card clock edge
  logic [ACMD_W-1:0] acmd_prev_q;
  wire acmd_rise = |(s_acmd & ~acmd_prev_q); // [RL8]
  wire tok_bad   = s_tok_valid & (s_tok != sdi_pkg::CRC_TOK_OK);
  wire desc_bad  = s_fetch & s_desc_load & ~s_desc_valid; // [RL7]
  wire adma_ev   = s_adma_err | desc_bad; // [RL5]

  logic [15:0] norm_ev, err_ev;
  always_comb begin
    norm_ev = 16'h0000;
    err_ev  = 16'h0000;
    norm_ev[sdi_pkg::NS_CMD_DONE]  = resp_ok; // [RL2]
    norm_ev[sdi_pkg::NS_XFER_DONE] = s_xfer_done; // [RL1]
    norm_ev[sdi_pkg::NS_CARD_IRQ]  = s_card_irq; // [RL13]
    err_ev[sdi_pkg::ES_CMD_TOUT]   = cmd_tout_ev; // [RL2]
    err_ev[sdi_pkg::ES_CMD_CRC]    = resp_ok & s_resp_crc;
    err_ev[sdi_pkg::ES_CMD_EBIT]   = resp_ok & ~s_resp_ebit; // [RL16]
    err_ev[sdi_pkg::ES_CMD_IDX]    = resp_ok & (s_resp_idx != issued_idx_q); // [RL15]
    err_ev[sdi_pkg::ES_DAT_TOUT]   = s_data_tout & ~s_xfer_done; // [RL1]
    err_ev[sdi_pkg::ES_DAT_CRC]    = (s_rd_end & s_rd_crc) | tok_bad; // [RL12]
    err_ev[sdi_pkg::ES_DAT_EBIT]   = (s_rd_end & ~s_rd_ebit) | (s_tok_valid & ~s_tok_ebit); // [RL11]
    err_ev[sdi_pkg::ES_AUTO_STOP]  = acmd_rise | s_acmd_skip; // [RL8] [RL9]
    err_ev[sdi_pkg::ES_ADMA]       = adma_ev;
  end

  // Status, enable and pending-clear registers
  logic [15:0] norm_sts_q, err_sts_q, norm_clr_q, err_clr_q;
  logic [15:0] norm_sen_q, err_sen_q, norm_sig_q, err_sig_q;
  logic [1:0]  adma_st_q;
  logic        card_irq_prev_q;

  wire [31:0] err_idx = (CHANNEL == 0) ? sdi_pkg::ERR_STS_CH0_IDX : sdi_pkg::ERR_STS_CH1_IDX;
  wire sel_err  = hit(paddr_i, err_idx);
  wire sel_norm = hit(paddr_i, sdi_pkg::NORM_STS_IDX);
  wire sel_sen  = hit(paddr_i, sdi_pkg::STS_EN_IDX);
  wire sel_sig  = hit(paddr_i, sdi_pkg::SIG_EN_IDX);
  wire sel_adma = hit(paddr_i, sdi_pkg::ADMA_STS_IDX);
  wire mapped   = sel_err | sel_norm | sel_sen | sel_sig | sel_adma;
  wire wr_acc   = psel_i & penable_i & pwrite_i & mapped;

  wire [15:0] wr_norm_clr = (wr_acc & sel_norm) ? (pwdata_i[15:0] & sdi_pkg::NORM_MASK) : 16'h0;
  wire [15:0] wr_err_clr  = (wr_acc & sel_err) ? (pwdata_i[15:0] & sdi_pkg::ERR_MASK) : 16'h0; // [RL4]

  // Card irq status only sets on a fresh assertion, so a held level stays cleared
  wire [15:0] card_bit  = 16'h0001 << sdi_pkg::NS_CARD_IRQ;
  wire        card_new  = s_card_irq & ~card_irq_prev_q;
  wire [15:0] card_rise = card_new ? card_bit : 16'h0000;
  wire [15:0] norm_set  = (norm_ev & ~(card_bit & ~card_rise)) & norm_sen_q & sdi_pkg::NORM_MASK;
  wire [15:0] err_set   = err_ev & err_sen_q & sdi_pkg::ERR_MASK; // [RL3] [RL10] [RL17]

  // Clears land on the card clock edge and lose to a set on that edge
  wire [15:0] norm_sts_d = sd_edge ? ((norm_sts_q & ~norm_clr_q) | norm_set) : norm_sts_q; // [RL14]
  wire [15:0] err_sts_d  = sd_edge ? ((err_sts_q & ~err_clr_q) | err_set) : err_sts_q; // [RL4] [RL14]
  wire [15:0] norm_clr_d = (sd_edge ? 16'h0 : norm_clr_q) | wr_norm_clr;
  wire [15:0] err_clr_d  = (sd_edge ? 16'h0 : err_clr_q) | wr_err_clr;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cmd_st_q        <= sdi_pkg::SDI_CMD_IDLE;
      tout_cnt_q      <= 8'h00;
      acmd_prev_q     <= '0;
      card_irq_prev_q <= 1'b0;
    end else if (sd_edge) begin
      cmd_st_q        <= cmd_st_d;
      tout_cnt_q      <= tout_cnt_d;
      acmd_prev_q     <= s_acmd;
      card_irq_prev_q <= s_card_irq;
    end
  end

  // Index of the command in flight, compared against the response index
  wire idx_load  = sd_edge & s_cmd_start & (cmd_st_q == sdi_pkg::SDI_CMD_IDLE);
  // Engine state captured at each DMA error for software to inspect
  wire adma_load = sd_edge & adma_ev;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      issued_idx_q <= 6'h00;
    end else if (idx_load) begin
      issued_idx_q <= s_cmd_idx;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adma_st_q <= 2'h0;
    end else if (adma_load) begin
      adma_st_q <= s_adma_state; // [RL6]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      norm_sts_q <= sdi_pkg::STS_RST;
      err_sts_q  <= sdi_pkg::STS_RST;
      norm_clr_q <= 16'h0000;
      err_clr_q  <= 16'h0000;
    end else begin
      norm_sts_q <= norm_sts_d;
      err_sts_q  <= err_sts_d;
      norm_clr_q <= norm_clr_d;
      err_clr_q  <= err_clr_d;
    end
  end

  // Enable registers: normal enables in the low half, error enables in the high half
  wire wr_sen = wr_acc & sel_sen;
  wire wr_sig = wr_acc & sel_sig;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      {err_sen_q, norm_sen_q} <= sdi_pkg::EN_RST;
    end else if (wr_sen) begin
      norm_sen_q <= pwdata_i[15:0] & sdi_pkg::NORM_MASK;
      err_sen_q  <= pwdata_i[31:16] & sdi_pkg::ERR_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      {err_sig_q, norm_sig_q} <= sdi_pkg::EN_RST;
    end else if (wr_sig) begin
      norm_sig_q <= pwdata_i[15:0] & sdi_pkg::NORM_MASK;
      err_sig_q  <= pwdata_i[31:16] & sdi_pkg::ERR_MASK;
    end
  end

  // Read data, registered in the setup cycle
  // The top bit of normal status summarises the error status word
  wire [15:0] err_sum = {15'h0000, |err_sts_q} << sdi_pkg::NS_ERR_SUM;
  wire [15:0] norm_rd = norm_sts_q | err_sum;
  wire [31:0] rd_mux  = sel_err  ? {16'h0000, err_sts_q} :
                        sel_norm ? {16'h0000, norm_rd} :
                        sel_sen  ? {err_sen_q, norm_sen_q} :
                        sel_sig  ? {err_sig_q, norm_sig_q} :
                        sel_adma ? {30'h0, adma_st_q} : 32'h0;

  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
  wire irq_d    = |((norm_sts_q & norm_sig_q) | (err_sts_q & err_sig_q)); // [RL3]

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0;
    end else if (rd_setup) begin
      prdata_o <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_request_out_o <= 1'b0;
    end else begin
      irq_request_out_o <= irq_d; // [RL3]
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
endmodule

// file: sdi_irq_status_properties.sv
// Port checker for the SD host interrupt status block
`timescale 1ns/100ps
module sdi_irq_status_chk (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Interrupt
  input wire logic        irq_request_out_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire        acc = psel_i & penable_i;
  wire [11:0] a   = paddr_i[11:0];
  wire        hit = (a == 12'h0c0) | (a == 12'h0c8) | (a == 12'h0d0) | (a == 12'h0d8)
                    | (a == 12'h150);
  wire        rde = acc & !pwrite_i & (a == 12'h0c8);
  wire        wre = acc & pwrite_i & (a == 12'h0c8);
  a_ready_high: assert property (psel_i |-> pready_o) else $error("pready low");
  a_unmapped_err: assert property (acc & !hit |-> pslverr_o) else $error("no slverr");
  a_mapped_ok: assert property (!acc | hit |-> !pslverr_o) else $error("bad slverr");
  a_unmapped_zero: assert property (acc & !pwrite_i & !hit |-> prdata_o == 32'h0)
    else $error("unmapped data");
  a_rsvd_zero: assert property (rde |-> prdata_o[15:10] == 6'h00) else $error("rsvd");
  a_curlim_zero: assert property (rde |-> !prdata_o[7]) else $error("cur lim");
  a_clear_lag: assert property (wre & irq_request_out_o |=> irq_request_out_o)
    else $error("irq dropped at once");
  a_irq_reset: assert property ($rose(nrst_i) |-> !irq_request_out_o) else $error("irq");
  a_rdata_hold: assert property (acc & !pwrite_i |=> $stable(prdata_o)) else $error("rdata");
  c_err_read: cover property (rde);
  c_irq_rise: cover property ($rose(irq_request_out_o));
  c_slverr: cover property (acc & pslverr_o);
endmodule
bind sdi_irq_status sdi_irq_status_chk u_chk (.ref_clk_i, .nrst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .irq_request_out_o);

// file: sdi_card_model.sv
// Card side model: card clock that runs only in frames, and event pulses
`timescale 1ns/100ps
module sdi_card_model (
  // Card clock and events
  output logic       sdclk_o,
  output logic [8:0] ev_o
);
  initial begin
    sdclk_o = 1'b0;
    ev_o    = 9'h000;
  end
  // Events change while the clock is low and stand one period
  task automatic frame(input logic [8:0] m, input int n);
    ev_o <= m;
    for (int i = 0; i < n; i++) begin
      #24 sdclk_o <= 1'b1;
      #24 sdclk_o <= 1'b0;
      ev_o <= 9'h000;
    end
  endtask
endmodule

// file: test_sdi_irq_status.sv
// Self-checking bench for the SD host interrupt status block
`timescale 1ns/100ps
module test_sdi_irq_status;
  logic        clk, nrst, psel, pen, pwr, err, qe, irq, rdy, rebit, rcrc, dbit, dcrc;
  logic        tbit, fst, dval, cirq, sdclk;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [5:0]  cidx, ridx;
  logic [2:0]  tok;
  logic [1:0]  ast;
  logic [4:0]  acmd;
  logic [8:0]  ev;
  int          bad_count, tests_run, cyc;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sdi_irq_status u_dut (.ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
    .pslverr_o(err), .sdclk_i(sdclk), .cmd_start_i(ev[0]), .cmd_index_i(cidx),
    .resp_done_i(ev[1]), .resp_index_i(ridx), .resp_end_bit_i(rebit), .resp_crc_err_i(rcrc),
    .xfer_done_i(ev[2]), .data_tout_i(ev[3]), .rd_end_i(ev[4]), .rd_end_bit_i(dbit),
    .rd_crc_err_i(dcrc), .tok_valid_i(ev[5]), .tok_i(tok), .tok_end_bit_i(tbit),
    .adma_err_i(ev[6]), .descriptor_fetch_state_i(fst), .desc_load_i(ev[7]),
    .desc_valid_i(dval), .adma_state_i(ast), .acmd_err_i(acmd), .acmd_skip_i(ev[8]),
    .card_irq_i(cirq), .irq_request_out_o(irq));
  sdi_card_model u_card (.sdclk_o(sdclk), .ev_o(ev));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {20'h00000, a};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q  = prdata;
    qe = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rs(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  task automatic sd(input logic [8:0] m, input int n);
    u_card.frame(m, n);
    repeat (8) @(posedge clk);
  endtask
  task automatic clr();
    apb(1'b1, 12'h0c0, 32'h0000ffff);
    apb(1'b1, 12'h0c8, 32'h0000ffff);
    sd(9'h000, 1);
  endtask
  task automatic t_reset();
    rs("err", 12'h0c8, 32'h0);
    rs("norm", 12'h0c0, 32'h0);
    rs("sts_en", 12'h0d0, 32'h0);
    rs("sig_en", 12'h0d8, 32'h0);
    rs("unmapped", 12'h004, 32'h0);
    chk("slverr", {31'h0, qe}, 32'h1);
    apb(1'b1, 12'h0d0, 32'hffffffff);
  endtask
  task automatic t_cmd();
    sd(9'h001, 1);
    sd(9'h002, 1);
    rs("cmd_done", 12'h0c0, 32'h1);
    rs("cmd_ok", 12'h0c8, 32'h0);
    sd(9'h001, 1);
    ridx  <= 6'h06;
    rebit <= 1'b0;
    sd(9'h002, 1);
    rs("idx_ebit", 12'h0c8, 32'hc);
    apb(1'b1, 12'h0c8, 32'h4);
    sd(9'h000, 1);
    rs("w1c", 12'h0c8, 32'h8);
    apb(1'b1, 12'h0c8, 32'h0);
    sd(9'h000, 1);
    rs("w0", 12'h0c8, 32'h8);
    clr();
    sd(9'h001, 70);
    rs("tout", 12'h0c8, 32'h1);
    rs("tout_norm", 12'h0c0, 32'h8000);
    clr();
  endtask
  task automatic t_data();
    sd(9'h00c, 1);
    rs("xfer", 12'h0c0, 32'h2);
    rs("xfer_err", 12'h0c8, 32'h0);
    clr();
    sd(9'h008, 1);
    rs("dtout", 12'h0c8, 32'h10);
    clr();
    dbit <= 1'b0;
    dcrc <= 1'b1;
    sd(9'h010, 1);
    rs("rd_err", 12'h0c8, 32'h60);
    clr();
    tok <= 3'h5;
    sd(9'h020, 1);
    rs("tok_bad", 12'h0c8, 32'h20);
    clr();
    tok  <= 3'h2;
    tbit <= 1'b0;
    sd(9'h020, 1);
    rs("tok_ebit", 12'h0c8, 32'h40);
    tbit <= 1'b1;
    clr();
  endtask
  task automatic t_dma();
    ast <= 2'h2;
    sd(9'h040, 1);
    ast <= 2'h1;
    rs("dma", 12'h0c8, 32'h200);
    rs("dma_st", 12'h150, 32'h2);
    clr();
    fst  <= 1'b1;
    dval <= 1'b0;
    sd(9'h080, 1);
    rs("desc", 12'h0c8, 32'h200);
    clr();
    acmd <= 5'h04;
    sd(9'h000, 1);
    rs("acmd", 12'h0c8, 32'h100);
    clr();
    rs("acmd_lvl", 12'h0c8, 32'h0);
    sd(9'h100, 1);
    rs("skip", 12'h0c8, 32'h100);
    clr();
  endtask
  task automatic t_irq();
    apb(1'b1, 12'h0d0, 32'hffdfffff);
    tok <= 3'h5;
    sd(9'h020, 1);
    rs("masked", 12'h0c8, 32'h0);
    apb(1'b1, 12'h0d0, 32'hffffffff);
    apb(1'b1, 12'h0d8, 32'h02000000);
    sd(9'h020, 1);
    chk("irq_off", {31'h0, irq}, 32'h0);
    sd(9'h040, 1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h0c8, 32'h0000ffff);
    repeat (20) @(posedge clk);
    chk("irq_lag", {31'h0, irq}, 32'h1);
    sd(9'h000, 1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    cirq <= 1'b1;
    sd(9'h000, 1);
    cirq <= 1'b0;
    sd(9'h000, 2);
    rs("card", 12'h0c0, 32'h100);
    apb(1'b1, 12'h0c0, 32'h100);
    sd(9'h000, 1);
    rs("card_clr", 12'h0c0, 32'h0);
  endtask
  task automatic t_rst();
    sd(9'h040, 1);
    chk("irq_pre", {31'h0, irq}, 32'h1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk("irq_rst", {31'h0, irq}, 32'h0);
    rs("err_rst", 12'h0c8, 32'h0);
    rs("sen_rst", 12'h0d0, 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {nrst, psel, pen, pwr, rcrc, dcrc, fst, cirq, paddr, pwdata, ast, acmd} = '0;
    {rebit, dbit, tbit, dval} = 4'hf;
    cidx = 6'h05;
    ridx = 6'h05;
    tok  = 3'h2;
    cyc  = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_cmd();
    t_data();
    t_dma();
    t_irq();
    t_rst();
    test_done();
  end
endmodule
